// *** oob_recovery_cfg.svh ***
/*
 * Timing counts, shadow register values and widths for the asynchronous
 * signal recovery logic of the host physical-layer controller.
 * Assumes a 125 MHz core clock; included by its bare name.
 */
`ifndef OOB_RECOVERY_CFG_SVH
`define OOB_RECOVERY_CFG_SVH

// Core clock period in picoseconds.
`define CLK_PERIOD_PS 8000
// Least retry-polling interval in milliseconds.
`define POLL_INTERVAL_MS 10
// Cycles in the least polling interval, rounded up.
`define POLL_INTERVAL_CYC \
	((`POLL_INTERVAL_MS * 64'd1000000000 + `CLK_PERIOD_PS - 1) \
	/ `CLK_PERIOD_PS)
// Bursts per COMRESET group; the count sent is a multiple of this.
`define RESET_BURST_GROUP 4'h6
// Shadow status value after a recovery COMRESET.
`define SHADOW_STATUS_RECOVERY 8'h7F
// Shadow value of every other command block register after recovery.
`define SHADOW_OTHER_RECOVERY 8'hFF
// Shadow status values that show an attached device.
`define SHADOW_STATUS_ATTACHED_BUSY 8'h80
`define SHADOW_STATUS_ATTACHED_FF 8'hFF
// Width of the poll counter.
`define POLL_CNT_W 24
// Number of shadow command block registers besides status.
`define SHADOW_OTHER_NUM 7

`endif

// *** oob_recovery_pkg.sv ***
/*
 * Types shared by the recovery controller and its shadow register bank.
 * Assumes the configuration header is compiled alongside.
 */
package oob_recovery_pkg;

	// States of the host initialization machine handled here.
	typedef enum logic [2:0]
	{
		HOST_INIT_RESET_STATE,
		HOST_AWAIT_INIT_SIGNAL_STATE,
		HOST_AWAIT_INIT_RELEASE_STATE,
		HOST_AWAIT_ALIGNMENT_STATE,
		HOST_LINK_UP_STATE,
		HOST_POWER_SAVE_STATE,
		HOST_RESUME_STATE
	} host_init_state_t;

	// One shadow command block register.
	typedef logic [7:0] shadow_byte_t;

	// Shadow load requests from the controller.
	typedef enum logic [1:0]
	{
		SHADOW_HOLD,
		SHADOW_LOAD_RECOVERY,
		SHADOW_LOAD_ATTACHED
	} shadow_cmd_t;

endpackage

// *** shadow_if.sv ***
/*
 * Carries shadow register load requests from the controller to the bank.
 * Assumes both ends share the core clock.
 */
`include "oob_recovery_cfg.svh"

interface shadow_if;
	import oob_recovery_pkg::*;

	// Load request, valid for one cycle.
	shadow_cmd_t cmd;
	// Pick 0x80 instead of 0xFF for the attached status value.
	logic attached_busy;
	// Current shadow status register value.
	shadow_byte_t status;
	// Current other shadow registers, flattened.
	logic [`SHADOW_OTHER_NUM*8-1:0] others;

	modport ctrl (output cmd, output attached_busy, input status,
		input others);
	modport bank (input cmd, input attached_busy, output status,
		output others);
endinterface

// *** shadow_bank.sv ***
/*
 * Shadow command block register bank, reloaded on recovery events.
 * Assumes a synchronous active-low reset and a clock enable.
 */
`include "oob_recovery_cfg.svh"

module shadow_bank
	import oob_recovery_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	shadow_if.bank sh
);
	// Registered status and the other shadow bytes.
	shadow_byte_t status;
	shadow_byte_t next_status;
	logic [`SHADOW_OTHER_NUM*8-1:0] others;
	logic [`SHADOW_OTHER_NUM*8-1:0] next_others;

	// Next status follows the load request.
	always_comb
	begin
		next_status = status;
		unique case (sh.cmd)
			SHADOW_LOAD_RECOVERY: next_status = `SHADOW_STATUS_RECOVERY;
			SHADOW_LOAD_ATTACHED: next_status = sh.attached_busy ?
				`SHADOW_STATUS_ATTACHED_BUSY :
				`SHADOW_STATUS_ATTACHED_FF;
			default: next_status = status;
		endcase
	end

	// Every other shadow byte is set to all ones on a recovery load.
	// Each byte has its own continuous assignment, so no two processes
	// share one variable.
	genvar g;
	generate
		for (g = 0; g < `SHADOW_OTHER_NUM; g++)
		begin : g_other
			assign next_others[g*8 +: 8] = (sh.cmd == SHADOW_LOAD_RECOVERY) ?
				`SHADOW_OTHER_RECOVERY : others[g*8 +: 8];
		end
	endgenerate

	// Registers the bank.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			status <= `SHADOW_STATUS_RECOVERY;
			others <= '1;
		end
		else if (ce_i)
		begin
			status <= next_status;
			others <= next_others;
		end
	end

	assign sh.status = status;
	assign sh.others = others;
endmodule // shadow_bank

// *** oob_recovery_ctrl.sv ***
/*
 * Host physical-layer initialization control with asynchronous signal
 * recovery: loss-of-signal detection, COMINIT classification, forced
 * transitions, resume tracking and retry polling.
 * Assumes OOB burst detection and generation outside; inputs synchronous.
 */
// Overview of operation
// - Loss of signal: ready drops entering no-comm.
// - Unsolicited COMINIT answered with COMRESET.
// - Unsolicited means first seen outside both await states.
// - Recovery COMRESET loads status 7F, others FF.
// - Solicited COMINIT sets status FF or 80.
// - Alignment detection must reject D10.2 aliasing.
// - Without recovery, COMINIT forces await-release state.
// - With recovery, unsolicited to reset, solicited release.
// - Resume-pending flag records power-state visits.
// - Resuming without COMWAKE: no COMRESET unless asked.
// - Resuming without COMWAKE: may resend COMWAKE.
// - Poll interval at least 10 ms, else infinite.
// - Device sleep support implies recovery support.
// - Reset state sends six-burst multiples; with recovery, clears resume.
// - Await-COMINIT timeout returns to reset state.
`include "oob_recovery_cfg.svh"

module oob_recovery_ctrl
	import oob_recovery_pkg::*;
(
	input wire logic CORE_CLK_I, // Core clock, 125 MHz.
	input wire logic RST_N_I, // Synchronous reset, active low.
	input wire logic CE_I, // Clock enable; state frozen while low.
	input wire logic RECOVERY_EN_I, // Recovery on; set with sleep.
	input wire logic POLL_EN_I, // Optional retry polling enabled.
	input wire logic RESET_REQ_I, // Explicit reset request.
	input wire logic COMINIT_DET_I, // COMINIT detection level.
	input wire logic COMWAKE_DET_I, // COMWAKE detection pulse.
	input wire logic ALIGN_DET_I, // Qualified ALIGN detection.
	input wire logic BURST_DONE_I, // One COMRESET burst sent.
	input wire logic POWER_SAVE_I, // Link entered a power state.
	input wire logic RESUME_REQ_I, // Resume from power state requested.
	input wire logic PHY_LINK_READY_I, // Physical-ready indication.
	input wire logic LINK_NO_COMM_ERROR_STATE_I, // Link no-comm error.
	input wire logic LINK_NO_COMM_STATE_I, // Link no-comm state.
	input wire logic ATTACHED_BUSY_I, // Report 80h on attach, not FFh.
	output logic COMRESET_O, // Send COMRESET bursts.
	output logic COMWAKE_O, // Send COMWAKE.
	output logic LOSS_OF_SIGNAL_O, // One-cycle loss-of-signal pulse.
	output logic RESUME_PENDING_FLAG_O, // Resume-pending flag.
	output logic UNSOLICITED_O, // Latched unsolicited class.
	output logic LINK_UP_O, // Host reached the link-up state.
	output oob_recovery_pkg::host_init_state_t STATE_O, // Current state.
	output oob_recovery_pkg::shadow_byte_t SHADOW_STATUS_O // Status.
);
	// Shadow register carrier.
	shadow_if sh ();

	// Machine state and counters.
	host_init_state_t state, next_state;
	logic [3:0] burst_cnt, next_burst_cnt; // Bursts in this group.
	logic [`POLL_CNT_W-1:0] poll_cnt, next_poll_cnt; // Await timer.
	logic resume_pending_flag, next_resume_pending_flag;
	logic unsolicited, next_unsolicited; // Latched class.
	logic cominit_prev, next_cominit_prev; // COMINIT last cycle.
	logic ready_prev, next_ready_prev; // Ready last cycle.
	logic loss, next_loss; // Loss-of-signal pulse.
	logic comreset, next_comreset;
	logic comwake, next_comwake;
	logic link_up, next_link_up;
	logic cominit_first; // Rising edge of COMINIT detection.
	logic poll_elapsed; // Retry interval elapsed.
	shadow_cmd_t next_cmd; // Shadow load for this cycle.

	assign cominit_first = COMINIT_DET_I && !cominit_prev;
	assign poll_elapsed = (poll_cnt >=
		`POLL_CNT_W'(`POLL_INTERVAL_CYC - 1));

	// Computes next state, counters, flags and shadow loads.
	always_comb
	begin
		next_state = state;
		next_burst_cnt = burst_cnt;
		next_poll_cnt = poll_cnt;
		next_resume_pending_flag = resume_pending_flag;
		next_unsolicited = unsolicited;
		next_cominit_prev = COMINIT_DET_I;
		next_ready_prev = PHY_LINK_READY_I;
		next_comreset = 1'b0;
		next_comwake = 1'b0;
		next_link_up = 1'b0;
		next_cmd = SHADOW_HOLD;
		// With recovery on, the reset state clears the flag even while a request holds it.
		if (RECOVERY_EN_I && state == HOST_INIT_RESET_STATE)
			next_resume_pending_flag = 1'b0;
		// Only a ready drop tied to a no-comm link state is a loss.
		next_loss = ready_prev && !PHY_LINK_READY_I &&
			(LINK_NO_COMM_ERROR_STATE_I || LINK_NO_COMM_STATE_I);

		// Classify at the first detection cycle and hold it.
		if (cominit_first)
			next_unsolicited = RECOVERY_EN_I &&
				(state != HOST_AWAIT_INIT_SIGNAL_STATE) &&
				(state != HOST_AWAIT_INIT_RELEASE_STATE);

		if (RESET_REQ_I)
		begin
			// Explicit reset takes the machine to reset.
			next_state = HOST_INIT_RESET_STATE;
			next_burst_cnt = 4'h0;
		end
		else if (cominit_first && state != HOST_AWAIT_INIT_RELEASE_STATE)
		begin
			if (next_unsolicited)
			begin
				// Forced move to reset, which sends COMRESET.
				next_state = HOST_INIT_RESET_STATE;
				// No gap in COMRESET when the move re-enters reset.
				next_comreset = 1'b1;
				next_burst_cnt = 4'h0;
				next_cmd = SHADOW_LOAD_RECOVERY;
			end
			else
			begin
				// Solicited, or no recovery: await release.
				next_state = HOST_AWAIT_INIT_RELEASE_STATE;
				if (state == HOST_AWAIT_INIT_SIGNAL_STATE)
					next_cmd = SHADOW_LOAD_ATTACHED;
			end
		end
		else
		begin
			unique case (state)
				HOST_INIT_RESET_STATE:
				begin
					// Send bursts in groups of six.
					next_comreset = 1'b1;
					if (BURST_DONE_I)
						next_burst_cnt = (burst_cnt == `RESET_BURST_GROUP - 4'h1) ?
							4'h0 : burst_cnt + 4'h1;
					if (BURST_DONE_I &&
						burst_cnt == `RESET_BURST_GROUP - 4'h1)
					begin
						next_comreset = 1'b0;
						next_state = HOST_AWAIT_INIT_SIGNAL_STATE;
						next_poll_cnt = '0;
						next_unsolicited = 1'b0;
					end
				end
				HOST_AWAIT_INIT_SIGNAL_STATE:
				begin
					// Time out only with recovery and polling on.
					next_poll_cnt = poll_cnt + 1'b1;
					if (RECOVERY_EN_I && POLL_EN_I && poll_elapsed)
					begin
						next_state = HOST_INIT_RESET_STATE;
						next_burst_cnt = 4'h0;
					end
				end
				HOST_AWAIT_INIT_RELEASE_STATE:
					// Leave once the device drops COMINIT.
					if (!COMINIT_DET_I)
					begin
						next_state = HOST_AWAIT_ALIGNMENT_STATE;
						next_unsolicited = 1'b0;
					end
				HOST_AWAIT_ALIGNMENT_STATE:
				begin
					// Detector outside must reject D10.2 aliasing.
					next_comwake = 1'b0;
					if (ALIGN_DET_I)
						next_state = HOST_LINK_UP_STATE;
				end
				HOST_LINK_UP_STATE:
				begin
					next_link_up = 1'b1;
					if (POWER_SAVE_I)
					begin
						next_state = HOST_POWER_SAVE_STATE;
						next_resume_pending_flag = 1'b1;
					end
				end
				HOST_POWER_SAVE_STATE:
					if (RESUME_REQ_I)
						next_state = HOST_RESUME_STATE;
				HOST_RESUME_STATE:
				begin
					// Resend COMWAKE; never COMRESET on its own.
					next_comwake = !COMWAKE_DET_I;
					if (COMWAKE_DET_I)
						next_state = HOST_AWAIT_ALIGNMENT_STATE;
				end
				default: next_state = HOST_INIT_RESET_STATE;
			endcase
		end
	end

	// Registers the controller state.
	always_ff @(posedge CORE_CLK_I)
	begin
		if (!RST_N_I)
		begin
			state <= HOST_INIT_RESET_STATE;
			burst_cnt <= 4'h0;
			poll_cnt <= '0;
			resume_pending_flag <= 1'b0;
			unsolicited <= 1'b0;
			cominit_prev <= 1'b0;
			ready_prev <= 1'b0;
			loss <= 1'b0;
			comreset <= 1'b0;
			comwake <= 1'b0;
			link_up <= 1'b0;
			sh.cmd <= SHADOW_HOLD;
		end
		else if (CE_I)
		begin
			state <= next_state;
			burst_cnt <= next_burst_cnt;
			poll_cnt <= next_poll_cnt;
			resume_pending_flag <= next_resume_pending_flag;
			unsolicited <= next_unsolicited;
			cominit_prev <= next_cominit_prev;
			ready_prev <= next_ready_prev;
			loss <= next_loss;
			comreset <= next_comreset;
			comwake <= next_comwake;
			link_up <= next_link_up;
			sh.cmd <= next_cmd;
		end
	end

	assign sh.attached_busy = ATTACHED_BUSY_I;

	// Shadow register bank.
	shadow_bank u_shadow (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.ce_i(CE_I),
		.sh(sh.bank)
	);

	assign COMRESET_O = comreset;
	assign COMWAKE_O = comwake;
	assign LOSS_OF_SIGNAL_O = loss;
	assign RESUME_PENDING_FLAG_O = resume_pending_flag;
	assign UNSOLICITED_O = unsolicited;
	assign LINK_UP_O = link_up;
	assign STATE_O = state;
	assign SHADOW_STATUS_O = sh.status;
endmodule // oob_recovery_ctrl

// *** oob_recovery_props.sv ***
/*
 * Port checker for the recovery controller, bound to its top module.
 * Assumes one core clock and a synchronous active-low reset.
 */
module oob_recovery_props
	import oob_recovery_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic RECOVERY_EN_I,
	input wire logic POLL_EN_I,
	input wire logic RESET_REQ_I,
	input wire logic COMINIT_DET_I,
	input wire logic PHY_LINK_READY_I,
	input wire logic LINK_NO_COMM_ERROR_STATE_I,
	input wire logic LINK_NO_COMM_STATE_I,
	input wire logic COMRESET_O,
	input wire logic LOSS_OF_SIGNAL_O,
	input wire logic RESUME_PENDING_FLAG_O,
	input wire logic UNSOLICITED_O,
	input wire oob_recovery_pkg::host_init_state_t STATE_O,
	input wire oob_recovery_pkg::shadow_byte_t SHADOW_STATUS_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	// A first COMINIT edge seen outside both await states.
	sequence s_unsol;
		CE_I && RECOVERY_EN_I && !RESET_REQ_I && $rose(COMINIT_DET_I)
		&& STATE_O != HOST_AWAIT_INIT_SIGNAL_STATE
		&& STATE_O != HOST_AWAIT_INIT_RELEASE_STATE;
	endsequence

	// A first COMINIT edge seen while awaiting it.
	sequence s_sol;
		CE_I && !RESET_REQ_I && $rose(COMINIT_DET_I)
		&& STATE_O == HOST_AWAIT_INIT_SIGNAL_STATE;
	endsequence

	a_unsol_reset:
	assert property (s_unsol |=> STATE_O == HOST_INIT_RESET_STATE
		&& UNSOLICITED_O) else $error("unsolicited move wrong");
	a_recovery_load:
	assert property (s_unsol |-> ##2 SHADOW_STATUS_O == 8'h7F
		&& COMRESET_O) else $error("recovery load wrong");
	a_sol_release:
	assert property (s_sol |=> STATE_O == HOST_AWAIT_INIT_RELEASE_STATE
		&& !UNSOLICITED_O ##1 (SHADOW_STATUS_O == 8'hFF
		|| SHADOW_STATUS_O == 8'h80)) else $error("solicited move wrong");
	a_norec_release:
	assert property (CE_I && !RECOVERY_EN_I && !RESET_REQ_I
		&& $rose(COMINIT_DET_I)
		&& STATE_O != HOST_AWAIT_INIT_RELEASE_STATE
		|=> STATE_O == HOST_AWAIT_INIT_RELEASE_STATE)
		else $error("release not forced");
	a_loss_pulse:
	assert property (CE_I && $fell(PHY_LINK_READY_I)
		&& (LINK_NO_COMM_ERROR_STATE_I || LINK_NO_COMM_STATE_I)
		|=> LOSS_OF_SIGNAL_O ##1 !LOSS_OF_SIGNAL_O)
		else $error("loss pulse wrong");
	a_no_false_loss:
	assert property (CE_I && !($fell(PHY_LINK_READY_I)
		&& (LINK_NO_COMM_ERROR_STATE_I || LINK_NO_COMM_STATE_I))
		|=> !LOSS_OF_SIGNAL_O) else $error("false loss pulse");
	a_reset_sends:
	assert property ((CE_I && !RESET_REQ_I
		&& STATE_O == HOST_INIT_RESET_STATE) [*3]
		|-> COMRESET_O) else $error("no reset bursts");
	a_resume_quiet:
	assert property (CE_I && STATE_O == HOST_RESUME_STATE |=> !COMRESET_O)
		else $error("COMRESET sent on resume");
	a_await_hold:
	assert property (CE_I && !POLL_EN_I && !RESET_REQ_I && !COMINIT_DET_I
		&& STATE_O == HOST_AWAIT_INIT_SIGNAL_STATE
		|=> STATE_O == HOST_AWAIT_INIT_SIGNAL_STATE)
		else $error("await left without cause");
	a_resume_clear:
	assert property (CE_I && RECOVERY_EN_I
		&& STATE_O == HOST_INIT_RESET_STATE
		|=> !RESUME_PENDING_FLAG_O) else $error("resume flag kept");
endmodule // oob_recovery_props

bind oob_recovery_ctrl oob_recovery_props u_oob_recovery_props (
	.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
	.RECOVERY_EN_I(RECOVERY_EN_I), .POLL_EN_I(POLL_EN_I),
	.RESET_REQ_I(RESET_REQ_I), .COMINIT_DET_I(COMINIT_DET_I),
	.PHY_LINK_READY_I(PHY_LINK_READY_I),
	.LINK_NO_COMM_ERROR_STATE_I(LINK_NO_COMM_ERROR_STATE_I),
	.LINK_NO_COMM_STATE_I(LINK_NO_COMM_STATE_I), .COMRESET_O(COMRESET_O),
	.LOSS_OF_SIGNAL_O(LOSS_OF_SIGNAL_O), .UNSOLICITED_O(UNSOLICITED_O),
	.RESUME_PENDING_FLAG_O(RESUME_PENDING_FLAG_O), .STATE_O(STATE_O),
	.SHADOW_STATUS_O(SHADOW_STATUS_O));

// *** device_phy_model.sv ***
/*
 * Behavioural attached device: acknowledges reset bursts and sends COMINIT.
 * Assumes the host core clock; COMINIT is sent only when told to.
 */
module device_phy_model
(
	input wire logic clk_i,
	input wire logic comreset_i, // Host is sending COMRESET.
	input wire logic answer_en_i, // Answer a finished COMRESET.
	input wire logic kick_i, // Send a COMINIT on command.
	output logic burst_done_o,
	output logic cominit_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic comreset_q = 1'b0; // Last seen COMRESET level.
	logic [2:0] hold = 3'h0; // Cycles of COMINIT still to send.

	initial burst_done_o = 1'b0;

	// Bursts end every other cycle; COMINIT lasts four cycles.
	always @(posedge clk_i)
	begin
		comreset_q <= comreset_i;
		burst_done_o <= comreset_i && !burst_done_o;
		if (kick_i || (answer_en_i && comreset_q && !comreset_i))
			hold <= 3'h4;
		else if (hold != 3'h0)
			hold <= hold - 3'h1;
	end

	assign cominit_o = (hold != 3'h0);
endmodule // device_phy_model

// *** tb_top.sv ***
/*
 * Self-checking bench for the recovery controller with a device model.
 * Assumes the checker is bound in; polling stays off to keep runs short.
 */
module tb_top
	import oob_recovery_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, recovery_en = 1'b1, poll_en = 1'b0;
	logic reset_req = 1'b0, ready = 1'b0, no_comm_err = 1'b0;
	logic no_comm = 1'b0, attached_busy = 1'b0, kick = 1'b0;
	logic answer_en = 1'b0, cominit, burst_done, comreset, loss;
	logic resume_pending, unsolicited;
	logic align = 1'b0, power_save = 1'b0, resume_req = 1'b0;
	logic comwake_det = 1'b0, ce = 1'b1, comwake, link_up;
	host_init_state_t state;
	shadow_byte_t shadow_status;
	int num_errors = 0, checks = 0, cycles = 0, bursts = 0;

	always #4 clk = ~clk;

	oob_recovery_ctrl u_oob_recovery_ctrl (.CORE_CLK_I(clk),
		.RST_N_I(rst_n), .CE_I(ce), .RECOVERY_EN_I(recovery_en),
		.POLL_EN_I(poll_en), .RESET_REQ_I(reset_req),
		.COMINIT_DET_I(cominit), .COMWAKE_DET_I(comwake_det),
		.ALIGN_DET_I(align), .BURST_DONE_I(burst_done),
		.POWER_SAVE_I(power_save), .RESUME_REQ_I(resume_req),
		.PHY_LINK_READY_I(ready),
		.LINK_NO_COMM_ERROR_STATE_I(no_comm_err),
		.LINK_NO_COMM_STATE_I(no_comm), .ATTACHED_BUSY_I(attached_busy),
		.COMRESET_O(comreset), .COMWAKE_O(comwake), .LOSS_OF_SIGNAL_O(loss),
		.RESUME_PENDING_FLAG_O(resume_pending),
		.UNSOLICITED_O(unsolicited), .LINK_UP_O(link_up), .STATE_O(state),
		.SHADOW_STATUS_O(shadow_status));

	device_phy_model u_device_phy_model (.clk_i(clk), .comreset_i(comreset),
		.answer_en_i(answer_en), .kick_i(kick), .burst_done_o(burst_done),
		.cominit_o(cominit));

	// Counts bursts acknowledged while the host sits in its reset state.
	always @(posedge clk)
		if (!rst_n)
			bursts <= 0;
		else if (state === HOST_INIT_RESET_STATE && burst_done === 1'b1)
			bursts <= bursts + 1;

	// Cuts a hung run short and reports it as a mismatch.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors = num_errors + 1;
			stop_test();
		end
	end

	// Prints the verdict and ends the run.
	task stop_test;
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Falling edge, where registered outputs have settled.
	task mid;
		@(negedge clk);
	endtask

	task check(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks = checks + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// Waits a bounded time for a state, then compares it.
	task wait_state(input host_init_state_t s);
		for (int i = 0; i < 300 && state !== s; i++)
			mid();
		check(8'(state), 8'(s), "state not reached");
	endtask

	task do_reset(input logic rec);
		@(posedge clk);
		rst_n <= 1'b0;
		recovery_en <= rec;
		tick(4);
		rst_n <= 1'b1;
	endtask

	// Sends one COMINIT from the device model.
	task send_cominit;
		tick(1);
		kick <= 1'b1;
		tick(1);
		kick <= 1'b0;
	endtask

	initial
	begin
		do_reset(1'b1);
		mid();
		check(shadow_status, 8'h7F, "reset status");
		tick(1);
		mid();
		check(8'(comreset), 8'h01, "no COMRESET");
		wait_state(HOST_AWAIT_INIT_SIGNAL_STATE);
		check(8'(bursts), 8'h06, "burst count");
		tick(40);
		mid();
		check(8'(state), 8'(HOST_AWAIT_INIT_SIGNAL_STATE), "left await");
		send_cominit();
		wait_state(HOST_AWAIT_INIT_RELEASE_STATE);
		check(8'(unsolicited), 8'h00, "wrong class");
		tick(1);
		mid();
		check(shadow_status, 8'hFF, "attach status");
		tick(1);
		reset_req <= 1'b1;
		tick(2);
		mid();
		check(8'(state), 8'(HOST_INIT_RESET_STATE), "no reset");
		tick(1);
		reset_req <= 1'b0;
		attached_busy <= 1'b1;
		answer_en <= 1'b1;
		send_cominit();
		tick(1);
		mid();
		check(8'(unsolicited), 8'h01, "not unsolicited");
		check(8'(state), 8'(HOST_INIT_RESET_STATE), "no forced reset");
		tick(1);
		mid();
		check(shadow_status, 8'h7F, "recovery status");
		check(8'(comreset), 8'h01, "no recovery COMRESET");
		wait_state(HOST_AWAIT_INIT_RELEASE_STATE);
		check(8'(unsolicited), 8'h00, "class kept");
		tick(1);
		mid();
		check(shadow_status, 8'h80, "busy attach status");
		answer_en <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			tick(1);
			ready <= 1'b1;
			no_comm <= 1'b0;
			no_comm_err <= 1'b0;
			tick(2);
			ready <= 1'b0;
			no_comm <= (i == 0);
			no_comm_err <= (i == 1);
			tick(1);
			mid();
			check(8'(loss), 8'(i < 2), "loss of signal");
		end
		// Alignment, power save, a frozen resume request, then COMWAKE.
		tick(1);
		align <= 1'b1;
		tick(1);
		align <= 1'b0;
		power_save <= 1'b1;
		tick(1);
		power_save <= 1'b0;
		mid();
		check(8'(link_up), 8'h01, "no link up");
		check(8'(resume_pending), 8'h01, "resume not pending");
		tick(1);
		ce <= 1'b0;
		resume_req <= 1'b1;
		tick(2);
		mid();
		check(8'(state), 8'(HOST_POWER_SAVE_STATE), "not frozen");
		tick(1);
		ce <= 1'b1;
		tick(1);
		resume_req <= 1'b0;
		tick(1);
		mid();
		check(8'(comwake), 8'h01, "no COMWAKE resend");
		check(8'(comreset), 8'h00, "COMRESET on resume");
		tick(1);
		comwake_det <= 1'b1;
		tick(1);
		comwake_det <= 1'b0;
		reset_req <= 1'b1;
		tick(2);
		reset_req <= 1'b0;
		mid();
		check(8'(comwake), 8'h00, "COMWAKE kept");
		check(8'(state), 8'(HOST_INIT_RESET_STATE), "no reset");
		check(8'(resume_pending), 8'h00, "resume flag kept");
		do_reset(1'b0);
		send_cominit();
		tick(1);
		mid();
		check(8'(state), 8'(HOST_AWAIT_INIT_RELEASE_STATE), "no release");
		stop_test();
	end
endmodule // tb_top
